// ### include/tch_pkg.sv
// Constants and types of the touch controller host port and mode control
// Operation
// - Full-rate mode scans continuously, default 100 frames/s, rate settable
// - Monitor mode scans at default 25 frames/s, host can change rate
// - Monitor mode runs only the presence check, full algorithms halted
// - A touch found while monitoring switches to full-rate mode at once
// - Serial port is closed while monitoring; no host data exchange
// - Power-down ignores every input except the host reset line
// - Host reset line low resets the device and wakes it from power-down
// - After any reset release the device enters full-rate mode
// - Interrupt output goes low when new touch data are ready
// - Serial port is slave only and never starts a transfer
// - Start, 7-bit address, direction bit (1 read), ack after each byte
// - Stop ends a packet; a repeated start ends it and begins the next
// - Serial port handles bit rates up to 400 kbit/s
// - After reset: initialise, then raise interrupt, then report points
// - Reporting starts no later than 200 ms after reset release
`default_nettype none
package tch_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 32'h0BEB_C200;
  localparam int unsigned US_PER_S = 32'h000F_4240;
  localparam int unsigned INIT_TIME_US = 32'h0000_03E8;
  localparam int unsigned INIT_CYC = CLK_HZ / US_PER_S * INIT_TIME_US;
  localparam int unsigned REPORT_MAX_MS = 32'h0000_00C8;
  localparam int unsigned ACC_W = 32'h0000_001C;
  // ==========================================================
  // Rates and mode control
  localparam logic [7:0] DEF_ACT_FPS = 8'h64;
  localparam logic [7:0] DEF_MON_FPS = 8'h19;
  localparam logic [7:0] IDLE_FRAMES = 8'h32;
  // ==========================================================
  // Serial port
  localparam logic [6:0] OWN_ADDR = 7'h2A;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] SEL_ACT_FPS = 8'h00;
  localparam logic [7:0] SEL_MON_FPS = 8'h01;
  localparam logic [7:0] SEL_MODE = 8'h02;
  localparam logic [7:0] CMD_ACTIVE = 8'h00;
  localparam logic [7:0] CMD_MONITOR = 8'h01;
  localparam logic [7:0] CMD_SLEEP = 8'h02;
  localparam logic [2:0] REP_BYTES = 3'h5;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    TCH_INIT = 4'h1,
    TCH_ACTIVE = 4'h2,
    TCH_MONITOR = 4'h4,
    TCH_SLEEP = 4'h8
  } tch_mode_t;
  typedef enum logic [3:0] {
    TCH_LK_ADDR = 4'h1,
    TCH_LK_WRITE = 4'h2,
    TCH_LK_READ = 4'h4,
    TCH_LK_IDLE = 4'h8
  } tch_lk_t;
endpackage
`default_nettype wire

// ### rtl/tch_i2c_link.sv
// Two-wire slave bit engine clocked by the serial clock
`timescale 1ns/1ps
`default_nettype none
module tch_i2c_link (
  // Link clock and clears
  input wire logic scl_clk,
  input wire logic lk_clr,
  input wire logic lk_rst,
  // Data pin
  input wire logic sda_in,
  output var logic sda_out,
  output var logic sda_oe,
  // Core side
  input wire logic [6:0] own_addr,
  input wire logic [7:0] tx_byte,
  output var logic wr_tog,
  output var logic rd_tog,
  output var logic [7:0] rx_byte
);
  // ==========================================================
  // Bit counting
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  tch_pkg::tch_lk_t ph_r;
  logic ack_clk;
  logic match;
  assign ack_clk = (bit_cnt_r == tch_pkg::BYTE_BITS);
  assign match = (shift_r[7:1] == own_addr);

  always_ff @(posedge scl_clk or posedge lk_clr) begin
    if (lk_clr) begin
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ph_r <= tch_pkg::TCH_LK_ADDR;
    end else if (!ack_clk) begin
      shift_r <= {shift_r[6:0], sda_in};
      tx_r <= {tx_r[6:0], 1'b0};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end else begin
      bit_cnt_r <= 4'h0;
      case (ph_r)
        tch_pkg::TCH_LK_ADDR: begin
          if (!match) begin
            ph_r <= tch_pkg::TCH_LK_IDLE;
          end else if (shift_r[0]) begin
            ph_r <= tch_pkg::TCH_LK_READ;
            tx_r <= tx_byte;
          end else begin
            ph_r <= tch_pkg::TCH_LK_WRITE;
          end
        end
        tch_pkg::TCH_LK_READ: begin
          if (sda_in) begin
            ph_r <= tch_pkg::TCH_LK_IDLE;
          end else begin
            tx_r <= tx_byte;
          end
        end
        default: begin
          ph_r <= ph_r;
        end
      endcase
    end
  end

  // ==========================================================
  // Events toward the core
  always_ff @(posedge scl_clk or posedge lk_rst) begin
    if (lk_rst) begin
      wr_tog <= 1'b0;
      rd_tog <= 1'b0;
      rx_byte <= 8'h00;
    end else if (ack_clk && !lk_clr) begin
      if (ph_r == tch_pkg::TCH_LK_WRITE) begin
        rx_byte <= shift_r;
        wr_tog <= ~wr_tog;
      end
      if ((ph_r == tch_pkg::TCH_LK_ADDR && match && shift_r[0]) ||
          (ph_r == tch_pkg::TCH_LK_READ && !sda_in)) begin
        rd_tog <= ~rd_tog;
      end
    end
  end

  // ==========================================================
  // Open-drain driver, changes while the clock is low
  always_ff @(negedge scl_clk or posedge lk_clr) begin
    if (lk_clr) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ack_clk) begin
      sda_out <= 1'b0;
      sda_oe <= (ph_r == tch_pkg::TCH_LK_ADDR && match) ||
                (ph_r == tch_pkg::TCH_LK_WRITE);
    end else begin
      sda_out <= 1'b0;
      sda_oe <= (ph_r == tch_pkg::TCH_LK_READ) && !tx_r[7];
    end
  end
endmodule
`default_nettype wire

// ### rtl/tch_port_ctrl.sv
// Mode sequencing, frame pacing, interrupt and host port of the controller
`timescale 1ns/1ps
`default_nettype none
module tch_port_ctrl #(
  parameter int unsigned CLK_HZ_P = tch_pkg::CLK_HZ,
  parameter int unsigned INIT_CYC_P = tch_pkg::INIT_CYC
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Host pins
  input wire logic host_reset_line_n,
  input wire logic scl_clk,
  input wire logic sda_in,
  output var logic sda_out,
  output var logic sda_oe,
  output var logic int_n,
  // Touch engine
  input wire logic touch_seen,
  input wire logic data_valid,
  input wire logic [3:0] pt_count,
  input wire logic [11:0] pt_x,
  input wire logic [11:0] pt_y,
  output var logic scan_start,
  output var logic full_algo_en,
  output var logic presence_only,
  output var logic [3:0] mode_state
);
  // ==========================================================
  // Host reset line and internal reset
  logic hrst_s1_r;
  logic hrst_s2_r;
  logic rst_i;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrst_s1_r <= 1'b0;
      hrst_s2_r <= 1'b0;
    end else begin
      hrst_s1_r <= host_reset_line_n;
      hrst_s2_r <= hrst_s1_r;
    end
  end

  assign rst_i = rst || !hrst_s2_r;

  // ==========================================================
  // Serial pin sampling and start/stop detection
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_s3_r;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge core_clk) begin
    if (rst_i) begin
      pin_s1_r <= 2'h3;
      pin_s2_r <= 2'h3;
      pin_s3_r <= 2'h3;
    end else begin
      pin_s1_r <= {scl_clk, sda_in};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Bit 1 is the clock pin, bit 0 the data pin
  assign bus_start = pin_s2_r[1] && pin_s3_r[1] &&
                     pin_s3_r[0] && !pin_s2_r[0];
  assign bus_stop = pin_s2_r[1] && pin_s3_r[1] &&
                    !pin_s3_r[0] && pin_s2_r[0];

  // ==========================================================
  // Link clear: held while the port is closed, pulsed on start
  tch_pkg::tch_mode_t mode_r;
  tch_pkg::tch_mode_t mode_nxt;
  logic port_open;
  logic hold_r;
  logic lk_clr_r;
  logic lk_rst_r;

  assign port_open = (mode_r == tch_pkg::TCH_ACTIVE) ||
                     (mode_r == tch_pkg::TCH_INIT);

  always_ff @(posedge core_clk) begin
    if (rst_i) begin
      hold_r <= 1'b1;
    end else if (!port_open || bus_stop) begin
      hold_r <= 1'b1;
    end else if (bus_start) begin
      hold_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_i) begin
      lk_clr_r <= 1'b1;
      lk_rst_r <= 1'b1;
    end else begin
      lk_clr_r <= hold_r || bus_start || bus_stop || !port_open;
      lk_rst_r <= 1'b0;
    end
  end

  // ==========================================================
  // Link engine, slave only
  logic wr_tog;
  logic rd_tog;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte_r;

  tch_i2c_link u_link (
    .scl_clk(scl_clk),
    .lk_clr(lk_clr_r),
    .lk_rst(lk_rst_r),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .own_addr(tch_pkg::OWN_ADDR),
    .tx_byte(rd_byte_r),
    .wr_tog(wr_tog),
    .rd_tog(rd_tog),
    .rx_byte(rx_byte)
  );

  // ==========================================================
  // Event crossing from the link clock
  logic [1:0] tog_s1_r;
  logic [1:0] tog_s2_r;
  logic [1:0] tog_s3_r;
  logic wr_ev;
  logic rd_ev;

  always_ff @(posedge core_clk) begin
    if (rst_i) begin
      tog_s1_r <= 2'h0;
      tog_s2_r <= 2'h0;
      tog_s3_r <= 2'h0;
    end else begin
      tog_s1_r <= {wr_tog, rd_tog};
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
    end
  end

  assign wr_ev = tog_s2_r[1] ^ tog_s3_r[1];
  assign rd_ev = tog_s2_r[0] ^ tog_s3_r[0];

  // ==========================================================
  // Host writes: first byte selects, later bytes set the value
  logic wr_first_r;
  logic [7:0] sel_r;
  logic [7:0] act_fps_r;
  logic [7:0] mon_fps_r;
  logic val_wr;
  logic cmd_wr;

  assign val_wr = wr_ev && !wr_first_r;
  assign cmd_wr = val_wr && (sel_r == tch_pkg::SEL_MODE);

  always_ff @(posedge core_clk) begin
    if (rst_i || bus_start) begin
      wr_first_r <= 1'b1;
    end else if (wr_ev) begin
      wr_first_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_i) begin
      sel_r <= tch_pkg::SEL_ACT_FPS;
    end else if (wr_ev && wr_first_r) begin
      sel_r <= rx_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_i) begin
      act_fps_r <= tch_pkg::DEF_ACT_FPS;
      mon_fps_r <= tch_pkg::DEF_MON_FPS;
    end else if (val_wr && sel_r == tch_pkg::SEL_ACT_FPS) begin
      act_fps_r <= rx_byte;
    end else if (val_wr && sel_r == tch_pkg::SEL_MON_FPS) begin
      mon_fps_r <= rx_byte;
    end
  end

  // ==========================================================
  // Initialisation timer
  logic [23:0] init_cnt_r;
  logic init_done;

  assign init_done = (init_cnt_r == 24'(INIT_CYC_P));

  always_ff @(posedge core_clk) begin
    if (rst_i) begin
      init_cnt_r <= 24'h00_0000;
    end else if (mode_r == tch_pkg::TCH_INIT && !init_done) begin
      init_cnt_r <= init_cnt_r + 24'h00_0001;
    end
  end

  // ==========================================================
  // Frame pacing: rate accumulator, one frame per CLK_HZ_P overflow
  localparam logic [tch_pkg::ACC_W-1:0] ACC_TOP =
    tch_pkg::ACC_W'(CLK_HZ_P);
  logic [tch_pkg::ACC_W-1:0] acc_r;
  logic [tch_pkg::ACC_W-1:0] acc_sum;
  logic [7:0] fps_sel;
  logic frame_tick;

  always_comb begin
    fps_sel = 8'h00;
    if (mode_r == tch_pkg::TCH_ACTIVE) begin
      fps_sel = act_fps_r;
    end else if (mode_r == tch_pkg::TCH_MONITOR) begin
      fps_sel = mon_fps_r;
    end
  end

  assign acc_sum = acc_r + tch_pkg::ACC_W'(fps_sel);
  assign frame_tick = (acc_sum >= ACC_TOP);

  always_ff @(posedge core_clk) begin
    if (rst_i || mode_r != mode_nxt) begin
      acc_r <= '0;
    end else if (frame_tick) begin
      acc_r <= acc_sum - ACC_TOP;
    end else begin
      acc_r <= acc_sum;
    end
  end

  // ==========================================================
  // Idle frame count in full-rate mode
  logic [7:0] idle_cnt_r;
  logic idle_long;

  assign idle_long = (idle_cnt_r == tch_pkg::IDLE_FRAMES);

  always_ff @(posedge core_clk) begin
    if (rst_i || touch_seen || mode_r != tch_pkg::TCH_ACTIVE) begin
      idle_cnt_r <= 8'h00;
    end else if (frame_tick && !idle_long) begin
      idle_cnt_r <= idle_cnt_r + 8'h01;
    end
  end

  // ==========================================================
  // Mode sequencer
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      tch_pkg::TCH_INIT: begin
        if (init_done) begin
          mode_nxt = tch_pkg::TCH_ACTIVE;
        end
      end
      tch_pkg::TCH_ACTIVE: begin
        if (cmd_wr && rx_byte == tch_pkg::CMD_SLEEP) begin
          mode_nxt = tch_pkg::TCH_SLEEP;
        end else if (cmd_wr && rx_byte == tch_pkg::CMD_MONITOR) begin
          mode_nxt = tch_pkg::TCH_MONITOR;
        end else if (idle_long) begin
          mode_nxt = tch_pkg::TCH_MONITOR;
        end
      end
      tch_pkg::TCH_MONITOR: begin
        if (touch_seen) begin
          mode_nxt = tch_pkg::TCH_ACTIVE;
        end
      end
      tch_pkg::TCH_SLEEP: begin
        mode_nxt = tch_pkg::TCH_SLEEP;
      end
      default: begin
        mode_nxt = tch_pkg::TCH_INIT;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst_i) begin
      mode_r <= tch_pkg::TCH_INIT;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ==========================================================
  // Scan control outputs
  always_ff @(posedge core_clk) begin
    if (rst_i) begin
      scan_start <= 1'b0;
      full_algo_en <= 1'b0;
      presence_only <= 1'b0;
      mode_state <= tch_pkg::TCH_INIT;
    end else begin
      scan_start <= frame_tick;
      full_algo_en <= (mode_nxt == tch_pkg::TCH_ACTIVE);
      presence_only <= (mode_nxt == tch_pkg::TCH_MONITOR);
      mode_state <= mode_nxt;
    end
  end

  // ==========================================================
  // Report buffer, filled by finished full-rate frames
  logic [7:0] rep_mem [0:tch_pkg::REP_BYTES-3'h1];
  logic [2:0] rd_idx_r;
  logic rep_take;

  function automatic logic [7:0] tch_rep_byte(
    input logic [2:0] idx,
    input logic [3:0] cnt,
    input logic [11:0] x,
    input logic [11:0] y
  );
    case (idx)
      3'h0: tch_rep_byte = {4'h0, cnt};
      3'h1: tch_rep_byte = {4'h0, x[11:8]};
      3'h2: tch_rep_byte = x[7:0];
      3'h3: tch_rep_byte = {4'h0, y[11:8]};
      3'h4: tch_rep_byte = y[7:0];
      default: tch_rep_byte = 8'h00;
    endcase
  endfunction

  assign rep_take = data_valid && (mode_r == tch_pkg::TCH_ACTIVE);

  generate
    for (genvar gi = 0; gi < int'(tch_pkg::REP_BYTES); gi++) begin : g_rep
      always_ff @(posedge core_clk) begin
        if (rst_i) begin
          rep_mem[gi] <= 8'h00;
        end else if (rep_take) begin
          rep_mem[gi] <= tch_rep_byte(3'(gi), pt_count, pt_x, pt_y);
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst_i || bus_start) begin
      rd_idx_r <= 3'h0;
    end else if (rd_ev) begin
      if (rd_idx_r == tch_pkg::REP_BYTES - 3'h1) begin
        rd_idx_r <= 3'h0;
      end else begin
        rd_idx_r <= rd_idx_r + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_i) begin
      rd_byte_r <= 8'h00;
    end else begin
      rd_byte_r <= rep_mem[rd_idx_r];
    end
  end

  // ==========================================================
  // Interrupt: set on init done and new data, cleared by a read
  logic int_pend_r;

  always_ff @(posedge core_clk) begin
    if (rst_i) begin
      int_pend_r <= 1'b0;
    end else if (mode_nxt == tch_pkg::TCH_MONITOR ||
                 mode_nxt == tch_pkg::TCH_SLEEP) begin
      int_pend_r <= 1'b0;
    end else if (rep_take || (mode_r == tch_pkg::TCH_INIT && init_done)) begin
      int_pend_r <= 1'b1;
    end else if (rd_ev) begin
      int_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_i) begin
      int_n <= 1'b1;
    end else begin
      int_n <= !int_pend_r;
    end
  end
endmodule
`default_nettype wire

// ### sim/tch_port_ctrl_properties.sv
// Concurrent checks on the pins of the host port and mode control
`timescale 1ns/1ps
`default_nettype none
module tch_port_ctrl_properties #(
  parameter int unsigned CLK_HZ_P = 32'h0000_2710,
  parameter int unsigned INIT_CYC_P = 32'h0000_0032
) (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic host_reset_line_n,
  // Serial pins and interrupt
  input wire logic scl_clk,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic int_n,
  // Touch engine
  input wire logic touch_seen,
  input wire logic data_valid,
  input wire logic scan_start,
  input wire logic full_algo_en,
  input wire logic presence_only,
  input wire logic [3:0] mode_state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Helpers
  logic [4:0] mon_cnt_r;
  always_ff @(posedge core_clk) begin
    if (rst || mode_state != 4'h4) begin
      mon_cnt_r <= 5'h00;
    end else if (mon_cnt_r != 5'h1F) begin
      mon_cnt_r <= mon_cnt_r + 5'h01;
    end
  end
  sequence s_new_data;
    data_valid && mode_state == 4'h2;
  endsequence
  sequence s_quiet;
    (mode_state == 4'h4 || mode_state == 4'h8) [*3];
  endsequence
  sequence s_pin_high;
    host_reset_line_n [*3];
  endsequence
  // ==========================================================
  // Assertions
  AST_INIT_FIRST: assert property ($fell(rst) |-> mode_state == 4'h1
    && int_n ##1 mode_state == 4'h1) else $error("init not first");
  AST_INT_ON_DATA: assert property (s_new_data |-> ##2 !int_n)
    else $error("interrupt late");
  AST_INT_QUIET: assert property (s_quiet |-> int_n)
    else $error("interrupt in quiet mode");
  AST_MON_LIGHT: assert property ((mode_state == 4'h4) [*2] |->
    presence_only && !full_algo_en) else $error("monitor runs full");
  AST_ACT_FULL: assert property ((mode_state == 4'h2) [*2] |->
    full_algo_en && !presence_only) else $error("active not full");
  AST_WAKE: assert property (mode_state == 4'h4 && touch_seen |=>
    mode_state == 4'h2) else $error("no wake on touch");
  AST_SLEEP_HOLD: assert property (s_pin_high ##0 mode_state == 4'h8
    |=> mode_state == 4'h8) else $error("sleep left");
  AST_HOST_RST: assert property ((!host_reset_line_n) [*4] |->
    mode_state == 4'h1 && int_n && !sda_oe) else $error("no reset");
  AST_PORT_CLOSED: assert property (mon_cnt_r == 5'h1F |-> !sda_oe)
    else $error("port open in monitor");
  AST_OPEN_DRAIN: assert property (!sda_out)
    else $error("data pin driven high");
  AST_NO_INITIATE: assert property (scl_clk [*8] |-> !sda_oe)
    else $error("drive on idle bus");
  AST_SCAN_PULSE: assert property (scan_start |=> !scan_start)
    else $error("frame pulse too long");
endmodule
`default_nettype wire

// ### sim/tch_host_model.sv
// Two-wire bus master standing in for the host processor
`timescale 1ns/1ps
`default_nettype none
module tch_host_model (
  // Bus
  output var logic scl,
  output var logic pull_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // One bit of 64 ns, data set mid-low
  task automatic bit_cycle(input logic drive_low, output logic seen);
    #16 pull_low = drive_low;
    #16 scl = 1'b1;
    seen = sda;
    #32 scl = 1'b0;
  endtask
  // Only the master opens a transfer
  task automatic bus_start();
    #32 pull_low = 1'b1;
    #32 scl = 1'b0;
  endtask
  task automatic bus_restart();
    #16 pull_low = 1'b0;
    #16 scl = 1'b1;
    #32 pull_low = 1'b1;
    #32 scl = 1'b0;
  endtask
  task automatic bus_stop();
    #16 pull_low = 1'b1;
    #16 scl = 1'b1;
    #32 pull_low = 1'b0;
    #32;
  endtask
  // MSB first, then the slave answers
  task automatic put_byte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(!b[i], s);
    end
    bit_cycle(1'b0, s);
    acked = !s;
  endtask
  task automatic get_byte(input logic give_ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, s);
      b[i] = s;
    end
    bit_cycle(give_ack, s);
  endtask
endmodule
`default_nettype wire

// ### sim/tch_port_ctrl_test.sv
// Self-checking bench of the host port and mode control
`timescale 1ns/1ps
`default_nettype none
module tch_port_ctrl_test;
  localparam int unsigned CLK_HZ = 32'h0000_2710;
  localparam int unsigned INIT_CYC = 32'h0000_0032;
  logic core_clk, rst, host_reset_line_n, scl_clk, sda_in, sda_out, sda_oe;
  logic int_n, touch_seen, data_valid, scan_start, full_algo_en;
  logic presence_only, pull_low;
  logic [3:0] pt_count, mode_state;
  logic [11:0] pt_x, pt_y;
  int err_total, total_checks;
  int cycles = 0;
  // Wired-and data line with pull-up
  assign sda_in = !(sda_oe && !sda_out) && !pull_low;
  tch_port_ctrl #(.CLK_HZ_P(CLK_HZ), .INIT_CYC_P(INIT_CYC)) u_dut (
    .core_clk(core_clk), .rst(rst), .host_reset_line_n(host_reset_line_n),
    .scl_clk(scl_clk), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .int_n(int_n), .touch_seen(touch_seen), .data_valid(data_valid),
    .pt_count(pt_count), .pt_x(pt_x), .pt_y(pt_y), .scan_start(scan_start),
    .full_algo_en(full_algo_en), .presence_only(presence_only),
    .mode_state(mode_state));
  tch_host_model u_host (.scl(scl_clk), .pull_low(pull_low), .sda(sda_in));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = !core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("ERROR %0t run did not finish", $time);
      final_report();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic final_report();
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic period(input int exp);
    int n;
    n = 0;
    cyc(1);
    while (scan_start !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    n = 1;
    cyc(1);
    while (scan_start !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    check(16'(n), 16'(exp));
  endtask
  task automatic wr_pkt(input logic [6:0] a, input logic [7:0] sel,
                        input logic [7:0] v, output logic ok);
    logic k0, k1, k2;
    u_host.bus_start();
    u_host.put_byte({a, 1'b0}, k0);
    u_host.put_byte(sel, k1);
    u_host.put_byte(v, k2);
    u_host.bus_stop();
    ok = k0 && k1 && k2;
  endtask
  task automatic rd_pkt(output logic ok, output logic [39:0] d);
    logic [7:0] b;
    u_host.bus_start();
    u_host.put_byte({tch_pkg::OWN_ADDR, 1'b1}, ok);
    for (int i = 4; i >= 0; i--) begin
      u_host.get_byte(i != 0, b);
      d[i*8 +: 8] = b;
    end
    u_host.bus_stop();
    cyc(10);
  endtask
  task automatic pulse_data();
    data_valid = 1'b1;
    cyc(1);
    data_valid = 1'b0;
    cyc(2);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_init();
    check(16'(mode_state), 16'h0001);
    cyc(INIT_CYC + 4);
    check(16'(mode_state), 16'h0002);
    check(16'(int_n), 16'h0000);
    check(16'(full_algo_en), 16'h0001);
    period(CLK_HZ / 100);
  endtask
  task automatic t_report();
    logic ok;
    logic [39:0] d;
    rd_pkt(ok, d);
    check(16'(int_n), 16'h0001);
    pt_count = 4'h3;
    pt_x = 12'h5A3;
    pt_y = 12'h1C7;
    pulse_data();
    check(16'(int_n), 16'h0000);
    rd_pkt(ok, d);
    check(16'(ok), 16'h0001);
    check(d[39:24], 16'h0305);
    check(d[23:8], 16'hA301);
    check(16'(d[7:0]), 16'h00C7);
    check(16'(int_n), 16'h0001);
  endtask
  task automatic t_restart();
    logic k0, k1, k2, k3;
    logic [7:0] b;
    u_host.bus_start();
    u_host.put_byte({tch_pkg::OWN_ADDR, 1'b0}, k0);
    u_host.put_byte(tch_pkg::SEL_ACT_FPS, k1);
    u_host.put_byte(8'h32, k2);
    u_host.bus_restart();
    u_host.put_byte({tch_pkg::OWN_ADDR, 1'b1}, k3);
    u_host.get_byte(1'b0, b);
    u_host.bus_stop();
    check(16'({k0, k1, k2, k3}), 16'h000F);
    check(16'(b), 16'h0003);
    period(CLK_HZ / 50);
  endtask
  task automatic t_foreign();
    logic ok;
    wr_pkt(7'h11, tch_pkg::SEL_MODE, tch_pkg::CMD_SLEEP, ok);
    check(16'(ok), 16'h0000);
    cyc(20);
    check(16'(mode_state), 16'h0002);
  endtask
  task automatic t_monitor();
    logic ok;
    logic [39:0] d;
    wr_pkt(tch_pkg::OWN_ADDR, tch_pkg::SEL_MODE, tch_pkg::CMD_MONITOR, ok);
    cyc(10);
    check(16'({ok, mode_state}), 16'h0014);
    check(16'({presence_only, full_algo_en}), 16'h0002);
    check(16'(int_n), 16'h0001);
    period(CLK_HZ / 25);
    rd_pkt(ok, d);
    check(16'(ok), 16'h0000);
    pulse_data();
    check(16'(int_n), 16'h0001);
    touch_seen = 1'b1;
    cyc(1);
    check(16'(mode_state), 16'h0002);
    touch_seen = 1'b0;
  endtask
  task automatic t_sleep();
    logic ok;
    logic [39:0] d;
    wr_pkt(tch_pkg::OWN_ADDR, tch_pkg::SEL_MODE, tch_pkg::CMD_SLEEP, ok);
    cyc(10);
    check(16'({ok, mode_state}), 16'h0018);
    touch_seen = 1'b1;
    pulse_data();
    touch_seen = 1'b0;
    cyc(4);
    check(16'({int_n, mode_state}), 16'h0018);
    rd_pkt(ok, d);
    check(16'(ok), 16'h0000);
    host_reset_line_n = 1'b0;
    cyc(20);
    check(16'(mode_state), 16'h0001);
    host_reset_line_n = 1'b1;
    cyc(INIT_CYC + 8);
    check(16'(mode_state), 16'h0002);
    period(CLK_HZ / 100);
    // No touch for the idle frame count drops to monitoring
    cyc(int'(tch_pkg::IDLE_FRAMES) * CLK_HZ / 100);
    check(16'({int_n, mode_state}), 16'h0014);
  endtask
  initial begin
    rst = 1'b1;
    host_reset_line_n = 1'b1;
    touch_seen = 1'b0;
    data_valid = 1'b0;
    pt_count = 4'h0;
    pt_x = 12'h000;
    pt_y = 12'h000;
    err_total = 0;
    total_checks = 0;
    cyc(4);
    rst = 1'b0;
    t_init();
    t_report();
    t_restart();
    t_foreign();
    t_monitor();
    t_sleep();
    final_report();
  end
endmodule
bind tch_port_ctrl tch_port_ctrl_properties #(
  .CLK_HZ_P(CLK_HZ_P),
  .INIT_CYC_P(INIT_CYC_P)
) u_props (
  .core_clk(core_clk), .rst(rst), .host_reset_line_n(host_reset_line_n),
  .scl_clk(scl_clk), .sda_out(sda_out), .sda_oe(sda_oe), .int_n(int_n),
  .touch_seen(touch_seen), .data_valid(data_valid),
  .scan_start(scan_start), .full_algo_en(full_algo_en),
  .presence_only(presence_only), .mode_state(mode_state));
`default_nettype wire
